// *** rtl/frame_port_pkg.sv ***
package frame_port_pkg;
  localparam logic [7:0] OFS_FRAME_TRIM = 8'h0c;
  localparam logic [7:0] OFS_PORT0 = 8'h10;
  localparam logic [7:0] OFS_PORT1 = 8'h12;
  localparam logic [7:0] TRIM_RESET = 8'h40;
  localparam int TRIM_VALUE_W = 7;
  localparam logic [13:0] FRAME_BASE = 14'd11936;
  localparam logic [13:0] FRAME_LEN_RESET = 14'd12000;
  localparam logic [10:0] FRAME_COUNT_RESET = 11'h000;
  localparam int NUM_PORTS = 2;
  localparam int PSC_CONNECT = 0;
  localparam int PSC_ENABLE = 2;
  localparam int PSC_LINE_LO = 4;
  localparam int PSC_FIXED_ONE = 7;
  localparam int PSC_SUSPEND = 12;
  localparam logic [15:0] PSC_RESET = 16'h0080;
  localparam logic [1:0] LINE_SE0 = 2'b00;

  typedef enum {PORT_DISABLED, PORT_ENABLED, PORT_SUSPENDED} port_mode_t;

  typedef struct packed {
    logic connect;
    logic enable;
    logic suspend_req;
    logic suspended;
    logic [1:0] line;
  } port_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [1:0] byte_en;
    logic wr;
    logic rd;
    logic [15:0] wdata;
  } io_req_t;
endpackage

// *** rtl/usb_frame_timing_port_suspend.sv ***
`timescale 1ns/10ps
`default_nettype none
module usb_frame_timing_port_suspend (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic hc_reset_in,
  input wire logic global_reset_in,
  input wire frame_port_pkg::io_req_t io_req_in,
  input wire logic sof_clk_en_in,
  input wire logic [1:0] port_busy_in,
  input wire logic [1:0] connect_in,
  input wire logic [3:0] line_state_in,
  input wire logic [1:0] se0_req_in,
  output logic [15:0] io_rdata_out,
  output logic io_rvalid_out,
  output logic sof_out,
  output logic [10:0] frame_count_out,
  output logic [1:0] port_pass_data_out,
  output logic [1:0] port_drive_se0_out,
  output logic [1:0] port_resume_watch_out
);
  import frame_port_pkg::*;

  function automatic port_mode_t decode_mode(input port_state_t p);
    if (!p.enable) begin
      decode_mode = PORT_DISABLED;
    end else if (p.suspended) begin
      decode_mode = PORT_SUSPENDED;
    end else begin
      decode_mode = PORT_ENABLED;
    end
  endfunction

  function automatic logic [15:0] psc_word(input port_state_t p);
    logic [15:0] w;
    w = 16'h0000;
    w[PSC_CONNECT] = p.connect;
    w[PSC_ENABLE] = p.enable;
    w[PSC_LINE_LO +: 2] = p.line;
    w[PSC_FIXED_ONE] = 1'b1;
    w[PSC_SUSPEND] = p.suspended;
    psc_word = w;
  endfunction

  logic soft_reset;
  assign soft_reset = hc_reset_in | global_reset_in;

  // Frame timing state
  logic [7:0] trim_reg, trim_next;
  logic [13:0] frame_len_reg, frame_len_next;
  logic [13:0] sof_cnt_reg, sof_cnt_next;
  logic [10:0] frame_count_reg, frame_count_next;
  logic sof_reg, sof_next;
  logic boundary;

  assign boundary = sof_clk_en_in && (sof_cnt_reg == frame_len_reg - 14'd1);

  always_comb begin
    trim_next = trim_reg;
    frame_len_next = frame_len_reg;
    sof_cnt_next = sof_cnt_reg;
    frame_count_next = frame_count_reg;
    sof_next = 1'b0;
    if (io_req_in.wr && io_req_in.addr == OFS_FRAME_TRIM && io_req_in.byte_en[0]) begin
      trim_next = io_req_in.wdata[7:0];
    end
    if (boundary) begin
      sof_cnt_next = 14'd0;
      sof_next = 1'b1;
      // Latched only here or on soft reset, so a write never stretches the running frame
      frame_len_next = FRAME_BASE + {7'h00, trim_reg[TRIM_VALUE_W-1:0]};
      frame_count_next = frame_count_reg + 11'd1;
    end else if (sof_clk_en_in) begin
      sof_cnt_next = sof_cnt_reg + 14'd1;
    end
    if (soft_reset) begin
      trim_next = TRIM_RESET;
      frame_len_next = FRAME_LEN_RESET;
      sof_cnt_next = 14'd0;
      frame_count_next = FRAME_COUNT_RESET;
      sof_next = 1'b0;
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      trim_reg <= TRIM_RESET;
      frame_len_reg <= FRAME_LEN_RESET;
      sof_cnt_reg <= 14'd0;
      frame_count_reg <= FRAME_COUNT_RESET;
      sof_reg <= 1'b0;
    end else begin
      trim_reg <= trim_next;
      frame_len_reg <= frame_len_next;
      sof_cnt_reg <= sof_cnt_next;
      frame_count_reg <= frame_count_next;
      sof_reg <= sof_next;
    end
  end

  assign sof_out = sof_reg;
  assign frame_count_out = frame_count_reg;

  // Port state
  port_state_t port_reg [NUM_PORTS];
  port_state_t port_next [NUM_PORTS];
  logic [1:0] pass_reg, pass_next;
  logic [1:0] se0_reg, se0_next;
  logic [1:0] watch_reg, watch_next;

  genvar g;
  generate
    for (g = 0; g < NUM_PORTS; g++) begin : g_port
      logic psc_wr;
      // Partial writes are dropped; only full words are defined
      assign psc_wr = io_req_in.wr && io_req_in.byte_en == 2'b11 &&
                      io_req_in.addr == (g == 0 ? OFS_PORT0 : OFS_PORT1);

      always_comb begin
        port_next[g] = port_reg[g];
        port_next[g].connect = connect_in[g];
        port_next[g].line = line_state_in[2*g +: 2];
        if (psc_wr) begin
          port_next[g].enable = io_req_in.wdata[PSC_ENABLE];
          port_next[g].suspend_req = io_req_in.wdata[PSC_SUSPEND];
          if (!io_req_in.wdata[PSC_SUSPEND]) begin
            port_next[g].suspended = 1'b0;
          end
        end
        // Entry waits until the bus goes idle
        if (port_reg[g].suspend_req && !port_reg[g].suspended && !port_busy_in[g]) begin
          port_next[g].suspended = 1'b1;
        end
        if (soft_reset) begin
          port_next[g] = '0;
          port_next[g].line = LINE_SE0;
        end
        pass_next[g] = decode_mode(port_next[g]) == PORT_ENABLED;
        se0_next[g] = se0_req_in[g] | global_reset_in;
        watch_next[g] = decode_mode(port_next[g]) == PORT_SUSPENDED;
      end

      always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          port_reg[g] <= '0;
        end else begin
          port_reg[g] <= port_next[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pass_reg <= 2'b00;
      se0_reg <= 2'b00;
      watch_reg <= 2'b00;
    end else begin
      pass_reg <= pass_next;
      se0_reg <= se0_next;
      watch_reg <= watch_next;
    end
  end

  assign port_pass_data_out = pass_reg;
  assign port_drive_se0_out = se0_reg;
  assign port_resume_watch_out = watch_reg;

  // Register read path
  logic [15:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;

  always_comb begin
    rdata_next = rdata_reg;
    rvalid_next = io_req_in.rd;
    if (io_req_in.rd) begin
      case (io_req_in.addr)
        OFS_FRAME_TRIM: rdata_next = {8'h00, trim_reg};
        OFS_PORT0: rdata_next = psc_word(port_reg[0]);
        OFS_PORT1: rdata_next = psc_word(port_reg[1]);
        default: rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_reg <= 16'h0000;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign io_rdata_out = rdata_reg;
  assign io_rvalid_out = rvalid_reg;

  // Checking helpers
  logic [13:0] len_seen_reg;
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      len_seen_reg <= FRAME_LEN_RESET;
    end else if (boundary || soft_reset) begin
      len_seen_reg <= frame_len_next;
    end
  end

  property p_trim_reset;
    @(posedge mclk_in) disable iff (!rstn_in)
    soft_reset |=> trim_reg == TRIM_RESET && frame_len_reg == FRAME_LEN_RESET;
  endproperty
  a_trim_reset: assert property (p_trim_reset) else $error("trim not restored");

  property p_len_stable;
    @(posedge mclk_in) disable iff (!rstn_in)
    !boundary && !soft_reset |=> frame_len_reg == len_seen_reg;
  endproperty
  a_len_stable: assert property (p_len_stable) else $error("frame length changed midframe");

  property p_len_formula;
    @(posedge mclk_in) disable iff (!rstn_in)
    boundary && !soft_reset |=>
      frame_len_reg == FRAME_BASE + {7'h00, $past(trim_reg[6:0])};
  endproperty
  a_len_formula: assert property (p_len_formula) else $error("frame length wrong");

  property p_frame_step;
    @(posedge mclk_in) disable iff (!rstn_in)
    sof_out |-> frame_count_out == $past(frame_count_out) + 11'd1;
  endproperty
  a_frame_step: assert property (p_frame_step) else $error("frame count not stepped");

  property p_count_range;
    @(posedge mclk_in) disable iff (!rstn_in)
    sof_cnt_reg < frame_len_reg;
  endproperty
  a_count_range: assert property (p_count_range) else $error("sof counter overran");

  property p_port_reset;
    @(posedge mclk_in) disable iff (!rstn_in)
    soft_reset |=> !port_reg[0].enable && !port_reg[0].connect &&
      port_reg[0].line == LINE_SE0 && !port_pass_data_out[0];
  endproperty
  a_port_reset: assert property (p_port_reset) else $error("port not cleared");

  property p_hold_busy;
    @(posedge mclk_in) disable iff (!rstn_in)
    !port_reg[0].suspended && port_busy_in[0] |=> !port_reg[0].suspended;
  endproperty
  a_hold_busy: assert property (p_hold_busy) else $error("suspended during transaction");

  property p_pass_decode;
    @(posedge mclk_in) disable iff (!rstn_in)
    port_pass_data_out[0] == (port_reg[0].enable && !port_reg[0].suspended);
  endproperty
  a_pass_decode: assert property (p_pass_decode) else $error("pass data decode wrong");

  property p_watch_decode;
    @(posedge mclk_in) disable iff (!rstn_in)
    port_resume_watch_out[0] == (port_reg[0].enable && port_reg[0].suspended);
  endproperty
  a_watch_decode: assert property (p_watch_decode) else $error("watch decode wrong");

  property p_se0_pass;
    @(posedge mclk_in) disable iff (!rstn_in)
    se0_req_in[0] |=> port_drive_se0_out[0];
  endproperty
  a_se0_pass: assert property (p_se0_pass) else $error("se0 reset blocked");

  property p_readback;
    @(posedge mclk_in) disable iff (!rstn_in)
    io_req_in.rd && io_req_in.addr == OFS_PORT0 |=>
      io_rvalid_out && io_rdata_out[15:13] == 3'b000 &&
      io_rdata_out[PSC_SUSPEND] == $past(port_reg[0].suspended);
  endproperty
  a_readback: assert property (p_readback) else $error("port readback wrong");

  c_sof: cover property (@(posedge mclk_in) disable iff (!rstn_in) sof_out);
  c_suspend: cover property (@(posedge mclk_in) disable iff (!rstn_in)
    port_reg[0].suspend_req && port_busy_in[0] ##1 !port_busy_in[0] ##1 port_reg[0].suspended);
  c_se0_global: cover property (@(posedge mclk_in) disable iff (!rstn_in)
    global_reset_in ##1 port_drive_se0_out == 2'b11);
  c_trim_write: cover property (@(posedge mclk_in) disable iff (!rstn_in)
    io_req_in.wr && io_req_in.addr == OFS_FRAME_TRIM ##[1:200] sof_out);
endmodule
`default_nettype wire

// *** verification/usb_device_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module usb_device_model #(
  parameter int BUSY_CYCLES = 20
) (
  input wire logic clk_in,
  input wire logic attach_in,
  input wire logic go_in,
  output logic connect_out,
  output logic [1:0] line_out,
  output logic busy_out
);
  int left = 0;
  // Detached lines sit at SE0 through the host pull-downs
  assign connect_out = attach_in;
  assign line_out = attach_in ? 2'b01 : 2'b00;
  assign busy_out = (left != 0);
  always @(posedge clk_in) begin
    if (left != 0)
      left <= left - 1;
    else if (go_in)
      left <= BUSY_CYCLES;
  end
endmodule
`default_nettype wire

// *** verification/tb_usb_frame_timing_port_suspend.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_usb_frame_timing_port_suspend;
  import frame_port_pkg::*;
  logic mclk_in, rstn_in, hc_reset_in, global_reset_in, sof_clk_en_in, io_rvalid_out, sof_out;
  io_req_t io_req_in;
  logic [1:0] se0_req_in, attach, go;
  wire logic [1:0] port_busy_in, connect_in, pass, se0, watch;
  wire logic [3:0] line_state_in;
  logic [15:0] io_rdata_out;
  logic [10:0] frame_count_out, fc;
  integer num_errors = 0, n_checks = 0, cyc = 0, t_sof = 0, gap = 0;

  usb_frame_timing_port_suspend dut (.mclk_in(mclk_in), .rstn_in(rstn_in),
    .hc_reset_in(hc_reset_in), .global_reset_in(global_reset_in), .io_req_in(io_req_in),
    .sof_clk_en_in(sof_clk_en_in), .port_busy_in(port_busy_in), .connect_in(connect_in),
    .line_state_in(line_state_in), .se0_req_in(se0_req_in), .io_rdata_out(io_rdata_out),
    .io_rvalid_out(io_rvalid_out), .sof_out(sof_out), .frame_count_out(frame_count_out),
    .port_pass_data_out(pass), .port_drive_se0_out(se0), .port_resume_watch_out(watch));
  usb_device_model dev0 (.clk_in(mclk_in), .attach_in(attach[0]), .go_in(go[0]),
    .connect_out(connect_in[0]), .line_out(line_state_in[1:0]), .busy_out(port_busy_in[0]));
  usb_device_model dev1 (.clk_in(mclk_in), .attach_in(attach[1]), .go_in(go[1]),
    .connect_out(connect_in[1]), .line_out(line_state_in[3:2]), .busy_out(port_busy_in[1]));

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic io_write(input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
    @(negedge mclk_in);
    io_req_in = '{addr: a, byte_en: be, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge mclk_in);
    io_req_in.wr = 1'b0;
  endtask

  task automatic read_check(input logic [7:0] a, input logic [15:0] exp);
    @(negedge mclk_in);
    io_req_in = '{addr: a, byte_en: 2'b11, wr: 1'b0, rd: 1'b1, wdata: 16'h0000};
    @(negedge mclk_in);
    io_req_in.rd = 1'b0;
    check({15'h0000, io_rvalid_out}, 16'h0001);
    check(io_rdata_out, exp);
  endtask

  // Gap is taken at the edge after the pulse, so it is a whole frame length
  always @(posedge mclk_in) begin
    cyc = cyc + 1;
    if (sof_out === 1'b1) begin
      gap = cyc - t_sof;
      t_sof = cyc;
    end
  end

  task automatic wait_sof;
    int n = 0;
    while (sof_out !== 1'b1 && n < 13000) begin
      @(negedge mclk_in);
      n++;
    end
    if (n >= 13000) num_errors++;
    @(negedge mclk_in);
  endtask

  task automatic finish_test;
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end

  initial begin
    #400000;
    num_errors++;
    finish_test();
  end

  initial begin
    rstn_in = 1'b0;
    hc_reset_in = 1'b0;
    global_reset_in = 1'b0;
    sof_clk_en_in = 1'b1;
    se0_req_in = 2'b00;
    attach = 2'b00;
    go = 2'b00;
    io_req_in = '0;
    repeat (4) @(negedge mclk_in);
    rstn_in = 1'b1;
    read_check(OFS_FRAME_TRIM, {8'h00, TRIM_RESET});
    read_check(OFS_PORT0, PSC_RESET);
    read_check(OFS_PORT1, PSC_RESET);
    read_check(8'h20, 16'h0000);
    $display("test reset done");
    wait_sof();
    fc = frame_count_out;
    io_write(OFS_FRAME_TRIM, 2'b01, 16'h00ff);
    wait_sof();
    check(gap[15:0], 16'd12000);
    check({5'h00, frame_count_out}, {5'h00, fc + 11'd1});
    // Ten missing counter clocks must stretch this frame by ten
    sof_clk_en_in = 1'b0;
    repeat (10) @(negedge mclk_in);
    sof_clk_en_in = 1'b1;
    wait_sof();
    check(gap[15:0], 16'd12073);
    $display("test frame done");
    attach = 2'b01;
    io_write(OFS_PORT0, 2'b11, 16'he004);
    read_check(OFS_PORT0, 16'h0095);
    check({14'h0000, pass}, 16'h0001);
    go = 2'b01;
    io_write(OFS_PORT0, 2'b11, 16'h1004);
    go = 2'b00;
    read_check(OFS_PORT0, 16'h0095);
    check({14'h0000, pass}, 16'h0001);
    repeat (25) @(negedge mclk_in);
    read_check(OFS_PORT0, 16'h1095);
    check({12'h000, pass, watch}, 16'h0001);
    se0_req_in = 2'b01;
    repeat (2) @(negedge mclk_in);
    check({14'h0000, se0}, 16'h0001);
    se0_req_in = 2'b00;
    io_write(OFS_PORT0, 2'b01, 16'h0000);
    read_check(OFS_PORT0, 16'h1095);
    io_write(OFS_PORT0, 2'b11, 16'h1000);
    repeat (2) @(negedge mclk_in);
    check({14'h0000, pass}, 16'h0000);
    io_write(OFS_PORT0, 2'b11, 16'h0004);
    repeat (2) @(negedge mclk_in);
    check({14'h0000, pass}, 16'h0001);
    $display("test port done");
    io_write(OFS_FRAME_TRIM, 2'b01, 16'h0010);
    hc_reset_in = 1'b1;
    @(negedge mclk_in);
    hc_reset_in = 1'b0;
    read_check(OFS_FRAME_TRIM, 16'h0040);
    read_check(OFS_PORT0, 16'h0091);
    io_write(OFS_FRAME_TRIM, 2'b01, 16'h0010);
    read_check(OFS_FRAME_TRIM, 16'h0010);
    global_reset_in = 1'b1;
    @(negedge mclk_in);
    global_reset_in = 1'b0;
    check({14'h0000, se0}, 16'h0003);
    read_check(OFS_FRAME_TRIM, 16'h0040);
    $display("test resets done");
    finish_test();
  end
endmodule
`default_nettype wire
